// File: src/cdp_defines.svh
// Register offsets, field positions, reset values and ramp divisions of the digital path control.
`ifndef CDP_DEFINES_SVH
`define CDP_DEFINES_SVH

`define CDP_OFS_SOFT_MUTE 8'h3A
`define CDP_OFS_RAMP_FILT 8'h3B
`define CDP_OFS_ST_SELECT 8'h3C
`define CDP_OFS_ADC_CTRL 8'h40
`define CDP_OFS_LEFT_VOL 8'h42
`define CDP_OFS_RIGHT_VOL 8'h43
`define CDP_OFS_CLK_ST_GAIN 8'h44

`define CDP_BIT_MUTE 14
`define CDP_BIT_MUTE_MODE 14
`define CDP_BIT_MUTE_RATE 13
`define CDP_BIT_FILT_SHAPE 12
`define CDP_MSB_ST_LEFT 13
`define CDP_LSB_ST_LEFT 12
`define CDP_MSB_ST_RIGHT 11
`define CDP_LSB_ST_RIGHT 10
`define CDP_BIT_HPF_ON 15
`define CDP_MSB_HPF_CUT 9
`define CDP_LSB_HPF_CUT 8
`define CDP_BIT_INV_LEFT 1
`define CDP_BIT_INV_RIGHT 0
`define CDP_BIT_CH_ON 15
`define CDP_BIT_COMMIT 8
`define CDP_MSB_VOL 7
`define CDP_LSB_VOL 0
`define CDP_MSB_SVOL_LEFT 11
`define CDP_LSB_SVOL_LEFT 8
`define CDP_MSB_SVOL_RIGHT 7
`define CDP_LSB_SVOL_RIGHT 4
`define CDP_BIT_CLK_INV 3
`define CDP_MSB_DIV 2
`define CDP_LSB_DIV 0

`define CDP_RST_MUTE 1'h1
`define CDP_RST_HPF_ON 1'h1
`define CDP_RST_VOL 8'hC0
`define CDP_ST_NONE 2'h0
`define CDP_ST_LEFT 2'h1
`define CDP_ST_RIGHT 2'h2
`define CDP_DIV_RESERVED 3'h7

// Ramp step every 2 samples (24 kHz at 48 kHz) or every 32 samples (1.5 kHz at 48 kHz).
`define CDP_FAST_RAMP_SAMPLES 6'h02
`define CDP_SLOW_RAMP_SAMPLES 6'h20
`define CDP_FAST_RAMP_MAX_US 10700
`define CDP_SLOW_RAMP_MAX_US 171000

`endif

// File: src/cdp_pkg.sv
// Types of the digital path control block.
package cdp_pkg;

  typedef struct packed {
    logic [7:0] gain_l;
    logic [7:0] gain_r;
  } cdp_ramp_s;

  typedef struct packed {
    logic [15:0] rdata;
    logic mute;
    logic mute_mode;
    logic mute_rate;
    logic filt_shape;
    logic [1:0] st_sel_l;
    logic [1:0] st_sel_r;
    logic [1:0] st_src_l;
    logic [1:0] st_src_r;
    logic hpf_on;
    logic [1:0] hpf_cut;
    logic inv_l;
    logic inv_r;
    logic on_l;
    logic on_r;
    logic [7:0] pend_l;
    logic [7:0] pend_r;
    logic [7:0] act_l;
    logic [7:0] act_r;
    logic [3:0] svol_l;
    logic [3:0] svol_r;
    logic clk_inv;
    logic [2:0] div;
    logic [4:0] samp_cnt;
    logic ramp_tick;
    logic [4:0] acc;
    logic rate_tick;
    logic [15:0] out_l;
    logic [15:0] out_r;
    logic out_valid;
  } cdp_state_s;

endpackage : cdp_pkg

// File: src/cdp_ramp.sv
// Soft mute gain ramp for the two playback channels.
`timescale 1ns/1ps
`include "cdp_defines.svh"

module cdp_ramp (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control.
  input wire logic step_en,
  input wire logic mute,
  input wire logic unmute_ramp_select,
  input wire logic [7:0] target_l,
  input wire logic [7:0] target_r,
  // Applied gains.
  output logic [7:0] gain_l,
  output logic [7:0] gain_r
);

  cdp_pkg::cdp_ramp_s q;
  cdp_pkg::cdp_ramp_s d;

  // Muting always walks down one step per tick so the output fades rather than clicks.
  function automatic logic [7:0] next_gain(input logic [7:0] g, input logic [7:0] tgt,
                                           input logic m, input logic mode, input logic tick);
    logic [7:0] r;
    r = g;
    if (m) begin
      if (tick && g != 8'h00) begin
        r = g - 8'h01;
      end
    end else if (!mode || g > tgt) begin
      r = tgt;
    end else if (tick && g < tgt) begin
      r = g + 8'h01;
    end
    return r;
  endfunction : next_gain

  always_comb begin
    d.gain_l = next_gain(q.gain_l, target_l, mute, unmute_ramp_select, step_en);
    d.gain_r = next_gain(q.gain_r, target_r, mute, unmute_ramp_select, step_en);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign gain_l = q.gain_l;
  assign gain_r = q.gain_r;

endmodule : cdp_ramp

// File: src/cdp_ctrl.sv
// Register bank and control of the codec digital path.
// Behaviour
// - Soft mute mode 0: unmuting applies the playback gains at once.
// - Soft mute mode 1: unmuting ramps the playback gain up to the programmed gains.
// - Ramp speed 0 steps the ramp at half the sample rate.
// - Ramp speed 1 steps the ramp at one thirty-second of the sample rate.
// - Filter shape bit picks normal or sloping-stopband playback filter.
// - Record high-pass filter on while its bit is 1, which is the reset value.
// - Cut-off code selects first-order or one of three second-order filters.
// - Each record channel's invert bit negates its samples.
// - Record gains take effect only when a commit bit is written as 1.
// - Record gain code zero mutes that channel's output.
// - Each four-bit side-tone gain sets attenuation from -36 dB to 0 dB.
// - Rate divider divides the system clock by 1 to 6; code 7 is reserved.
`timescale 1ns/1ps
`include "cdp_defines.svh"

module cdp_ctrl (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control interface register port.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Playback gain targets and sample strobe.
  input wire logic [7:0] playback_left_gain,
  input wire logic [7:0] playback_right_gain,
  input wire logic sample_strobe,
  // Record sample stream.
  input wire logic rec_valid,
  input wire logic [15:0] rec_left_in,
  input wire logic [15:0] rec_right_in,
  output logic rec_out_valid,
  output logic [15:0] rec_left_out,
  output logic [15:0] rec_right_out,
  // Playback path controls.
  output logic [7:0] applied_left_gain,
  output logic [7:0] applied_right_gain,
  output logic playback_filter_shape,
  output logic [1:0] left_sidetone_source,
  output logic [1:0] right_sidetone_source,
  output logic [3:0] left_sidetone_gain,
  output logic [3:0] right_sidetone_gain,
  // Record path controls.
  output logic record_highpass_on,
  output logic [1:0] record_highpass_cutoff,
  output logic record_left_on,
  output logic record_right_on,
  output logic [7:0] record_left_gain,
  output logic [7:0] record_right_gain,
  output logic record_clock_invert,
  output logic record_rate_tick
);

  ////////////////////////////////////////////////////////////////////////////////

  cdp_pkg::cdp_state_s q;
  cdp_pkg::cdp_state_s d;

  // The unused code falls back to no mix rather than mixing something unexpected.
  function automatic logic [1:0] clean_src(input logic [1:0] sel);
    return (sel == 2'h3) ? `CDP_ST_NONE : sel;
  endfunction : clean_src

  // Divider ratio in half clock periods; zero marks the reserved code.
  function automatic logic [4:0] half_ratio(input logic [2:0] code);
    logic [4:0] r;
    r = 5'h00;
    unique case (code)
      3'h0: r = 5'h02;
      3'h1: r = 5'h03;
      3'h2: r = 5'h04;
      3'h3: r = 5'h06;
      3'h4: r = 5'h08;
      3'h5: r = 5'h0B;
      3'h6: r = 5'h0C;
      3'h7: r = 5'h00;
    endcase
    return r;
  endfunction : half_ratio

  // Negation saturates so the most negative sample does not wrap to itself.
  function automatic logic [15:0] shape_sample(input logic [15:0] x, input logic inv,
                                               input logic [7:0] gain);
    logic [15:0] r;
    r = x;
    if (gain == 8'h00) begin
      r = 16'h0000;
    end else if (inv) begin
      r = (x == 16'h8000) ? 16'h7FFF : 16'(~x + 16'h0001);
    end
    return r;
  endfunction : shape_sample

  function automatic logic [15:0] read_reg(input logic [7:0] a, input cdp_pkg::cdp_state_s s);
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      `CDP_OFS_SOFT_MUTE: r[`CDP_BIT_MUTE] = s.mute;
      `CDP_OFS_RAMP_FILT: begin
        r[`CDP_BIT_MUTE_MODE] = s.mute_mode;
        r[`CDP_BIT_MUTE_RATE] = s.mute_rate;
        r[`CDP_BIT_FILT_SHAPE] = s.filt_shape;
      end
      `CDP_OFS_ST_SELECT: begin
        r[`CDP_MSB_ST_LEFT:`CDP_LSB_ST_LEFT] = s.st_sel_l;
        r[`CDP_MSB_ST_RIGHT:`CDP_LSB_ST_RIGHT] = s.st_sel_r;
      end
      `CDP_OFS_ADC_CTRL: begin
        r[`CDP_BIT_HPF_ON] = s.hpf_on;
        r[`CDP_MSB_HPF_CUT:`CDP_LSB_HPF_CUT] = s.hpf_cut;
        r[`CDP_BIT_INV_LEFT] = s.inv_l;
        r[`CDP_BIT_INV_RIGHT] = s.inv_r;
      end
      `CDP_OFS_LEFT_VOL: begin
        r[`CDP_BIT_CH_ON] = s.on_l;
        r[`CDP_MSB_VOL:`CDP_LSB_VOL] = s.pend_l;
      end
      `CDP_OFS_RIGHT_VOL: begin
        r[`CDP_BIT_CH_ON] = s.on_r;
        r[`CDP_MSB_VOL:`CDP_LSB_VOL] = s.pend_r;
      end
      `CDP_OFS_CLK_ST_GAIN: begin
        r[`CDP_MSB_SVOL_LEFT:`CDP_LSB_SVOL_LEFT] = s.svol_l;
        r[`CDP_MSB_SVOL_RIGHT:`CDP_LSB_SVOL_RIGHT] = s.svol_r;
        r[`CDP_BIT_CLK_INV] = s.clk_inv;
        r[`CDP_MSB_DIV:`CDP_LSB_DIV] = s.div;
      end
      default: r = 16'h0000;
    endcase
    return r;
  endfunction : read_reg

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [5:0] lim;
    logic [4:0] hr;
    logic [4:0] acc2;
    lim = 6'h00;
    hr = 5'h00;
    acc2 = 5'h00;
    d = q;
    d.ramp_tick = 1'b0;
    d.rate_tick = 1'b0;
    d.out_valid = 1'b0;

    if (reg_wr) begin
      case (reg_addr)
        `CDP_OFS_SOFT_MUTE: d.mute = reg_wdata[`CDP_BIT_MUTE];
        `CDP_OFS_RAMP_FILT: begin
          d.mute_mode = reg_wdata[`CDP_BIT_MUTE_MODE];
          d.mute_rate = reg_wdata[`CDP_BIT_MUTE_RATE];
          d.filt_shape = reg_wdata[`CDP_BIT_FILT_SHAPE];
        end
        `CDP_OFS_ST_SELECT: begin
          d.st_sel_l = reg_wdata[`CDP_MSB_ST_LEFT:`CDP_LSB_ST_LEFT];
          d.st_sel_r = reg_wdata[`CDP_MSB_ST_RIGHT:`CDP_LSB_ST_RIGHT];
        end
        `CDP_OFS_ADC_CTRL: begin
          d.hpf_on = reg_wdata[`CDP_BIT_HPF_ON];
          d.hpf_cut = reg_wdata[`CDP_MSB_HPF_CUT:`CDP_LSB_HPF_CUT];
          d.inv_l = reg_wdata[`CDP_BIT_INV_LEFT];
          d.inv_r = reg_wdata[`CDP_BIT_INV_RIGHT];
        end
        `CDP_OFS_LEFT_VOL: begin
          d.on_l = reg_wdata[`CDP_BIT_CH_ON];
          d.pend_l = reg_wdata[`CDP_MSB_VOL:`CDP_LSB_VOL];
        end
        `CDP_OFS_RIGHT_VOL: begin
          d.on_r = reg_wdata[`CDP_BIT_CH_ON];
          d.pend_r = reg_wdata[`CDP_MSB_VOL:`CDP_LSB_VOL];
        end
        `CDP_OFS_CLK_ST_GAIN: begin
          d.svol_l = reg_wdata[`CDP_MSB_SVOL_LEFT:`CDP_LSB_SVOL_LEFT];
          d.svol_r = reg_wdata[`CDP_MSB_SVOL_RIGHT:`CDP_LSB_SVOL_RIGHT];
          d.clk_inv = reg_wdata[`CDP_BIT_CLK_INV];
          d.div = reg_wdata[`CDP_MSB_DIV:`CDP_LSB_DIV];
        end
        default: d = d;
      endcase
      // The commit strobe takes the pending values written in this same cycle.
      if ((reg_addr == `CDP_OFS_LEFT_VOL || reg_addr == `CDP_OFS_RIGHT_VOL)
          && reg_wdata[`CDP_BIT_COMMIT]) begin
        d.act_l = d.pend_l;
        d.act_r = d.pend_r;
      end
    end
    d.st_src_l = clean_src(d.st_sel_l);
    d.st_src_r = clean_src(d.st_sel_r);

    if (reg_rd) begin
      d.rdata = read_reg(reg_addr, q);
    end

    lim = q.mute_rate ? `CDP_SLOW_RAMP_SAMPLES : `CDP_FAST_RAMP_SAMPLES;
    if (sample_strobe) begin
      if ({1'b0, q.samp_cnt} >= lim - 6'h01) begin
        d.samp_cnt = 5'h00;
        d.ramp_tick = 1'b1;
      end else begin
        d.samp_cnt = q.samp_cnt + 5'h01;
      end
    end

    // Fractional ratios alternate period lengths; the average rate is exact.
    hr = half_ratio(q.div);
    acc2 = q.acc + 5'h02;
    // An accumulator left above a newly chosen ratio restarts, so no burst of ticks follows.
    if (q.div == `CDP_DIV_RESERVED || q.acc >= hr) begin
      d.acc = 5'h00;
    end else if (acc2 >= hr) begin
      d.acc = acc2 - hr;
      d.rate_tick = 1'b1;
    end else begin
      d.acc = acc2;
    end

    if (rec_valid) begin
      d.out_valid = 1'b1;
      d.out_l = shape_sample(rec_left_in, q.inv_l, q.act_l);
      d.out_r = shape_sample(rec_right_in, q.inv_r, q.act_r);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.mute <= `CDP_RST_MUTE;
      q.hpf_on <= `CDP_RST_HPF_ON;
      q.pend_l <= `CDP_RST_VOL;
      q.pend_r <= `CDP_RST_VOL;
      q.act_l <= `CDP_RST_VOL;
      q.act_r <= `CDP_RST_VOL;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  cdp_ramp u_ramp (
    .clk(clk),
    .rst_n(rst_n),
    .step_en(q.ramp_tick),
    .mute(q.mute),
    .unmute_ramp_select(q.mute_mode),
    .target_l(playback_left_gain),
    .target_r(playback_right_gain),
    .gain_l(applied_left_gain),
    .gain_r(applied_right_gain)
  );

  assign reg_rdata = q.rdata;
  assign rec_out_valid = q.out_valid;
  assign rec_left_out = q.out_l;
  assign rec_right_out = q.out_r;
  assign playback_filter_shape = q.filt_shape;
  assign left_sidetone_source = q.st_src_l;
  assign right_sidetone_source = q.st_src_r;
  assign left_sidetone_gain = q.svol_l;
  assign right_sidetone_gain = q.svol_r;
  assign record_highpass_on = q.hpf_on;
  assign record_highpass_cutoff = q.hpf_cut;
  assign record_left_on = q.on_l;
  assign record_right_on = q.on_r;
  assign record_left_gain = q.act_l;
  assign record_right_gain = q.act_r;
  assign record_clock_invert = q.clk_inv;
  assign record_rate_tick = q.rate_tick;

endmodule : cdp_ctrl

// File: verification/cdp_ctrl_sva.sv
// Port assertions of the digital path control block.
`timescale 1ns/1ps

module cdp_ctrl_sva (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  // Record valid input and observed outputs.
  input wire logic rec_valid,
  input wire logic rec_out_valid,
  input wire logic [15:0] rec_left_out,
  input wire logic playback_filter_shape,
  input wire logic [1:0] left_sidetone_source,
  input wire logic [1:0] right_sidetone_source,
  input wire logic [3:0] left_sidetone_gain,
  input wire logic [7:0] record_left_gain,
  input wire logic [7:0] record_right_gain,
  input wire logic record_rate_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] div_q;
  logic [1:0] age_q;
  logic commit;
  assign commit = reg_wr && reg_wdata[8] && (reg_addr == 8'h42 || reg_addr == 8'h43);
  // The divider is only judged once it has settled, so pipeline latency never fires it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q <= 3'h0;
      age_q <= 2'h0;
    end else if (reg_wr && reg_addr == 8'h44) begin
      div_q <= reg_wdata[2:0];
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  tick_every_cycle_a: assert property (age_q == 2'h3 && div_q == 3'h0 |-> record_rate_tick)
    else $error("rate tick missing at divide by one");
  reserved_no_tick_a: assert property (age_q == 2'h3 && div_q == 3'h7 |-> !record_rate_tick)
    else $error("rate tick seen with reserved divider");
  rec_answer_a: assert property (rec_valid |=> rec_out_valid)
    else $error("record output valid missing");
  rec_no_spurious_a: assert property (rec_out_valid |-> $past(rec_valid))
    else $error("record output valid without input");
  gain_hold_a: assert property (!$stable(record_left_gain) || !$stable(record_right_gain)
    |-> $past(commit) || !$past(rst_n)) else $error("record gain changed without commit");
  gain_commit_a: assert property (commit && reg_addr == 8'h42
    |=> record_left_gain == $past(reg_wdata[7:0])) else $error("record gain not committed");
  filter_shape_a: assert property (reg_wr && reg_addr == 8'h3B
    |=> playback_filter_shape == $past(reg_wdata[12])) else $error("filter shape wrong");
  source_map_a: assert property (reg_wr && reg_addr == 8'h3C |=> left_sidetone_source ==
    ($past(reg_wdata[13:12]) == 2'h3 ? 2'h0 : $past(reg_wdata[13:12])))
    else $error("left side-tone source wrong");
  no_unused_code_a: assert property (right_sidetone_source != 2'h3)
    else $error("unused side-tone code driven");
  sidetone_gain_a: assert property (reg_wr && reg_addr == 8'h44
    |=> left_sidetone_gain == $past(reg_wdata[11:8])) else $error("side-tone gain wrong");
  mute_output_a: assert property (rec_out_valid && $past(record_left_gain) == 8'h00
    |-> rec_left_out == 16'h0000) else $error("muted record channel not zero");
endmodule : cdp_ctrl_sva

bind cdp_ctrl cdp_ctrl_sva u_sva (
  .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .rec_valid(rec_valid), .rec_out_valid(rec_out_valid), .rec_left_out(rec_left_out),
  .playback_filter_shape(playback_filter_shape), .left_sidetone_source(left_sidetone_source),
  .right_sidetone_source(right_sidetone_source), .left_sidetone_gain(left_sidetone_gain),
  .record_left_gain(record_left_gain), .record_right_gain(record_right_gain),
  .record_rate_tick(record_rate_tick)
);

// File: verification/tb_cdp_ctrl.sv
// Self-checking testbench of the digital path control block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tb_cdp_ctrl;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, sample_strobe = 1'b0, rec_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00, pl_l = 8'h00, pl_r = 8'h00, pend_l, pend_r, act_l, act_r;
  logic [15:0] reg_wdata = 16'h0000, in_l = 16'h0000, in_r = 16'h0000, d, rdata, out_l, out_r;
  logic out_v, shape, hp_on, on_l, on_r, clk_inv, tick;
  logic [7:0] app_l, app_r, g_l, g_r;
  logic [1:0] src_l, src_r, cut;
  logic [3:0] sv_l, sv_r;
  logic [31:0] lfsr = 32'hDE1608E5;
  logic [7:0] ra [8] = '{8'h3A, 8'h3B, 8'h3C, 8'h40, 8'h42, 8'h43, 8'h44, 8'h41};
  logic [15:0] rv [8] = '{16'h4000, 0, 0, 16'h8000, 16'h00C0, 16'h00C0, 0, 0};
  logic [15:0] mk [8] = '{16'h4000, 16'h7000, 16'h3C00, 16'h8303, 16'h80FF, 16'h80FF,
    16'h0FFF, 0};
  logic [15:0] sh [8];
  int st [2] = '{2, 32};
  int dv [8] = '{264, 176, 132, 88, 66, 48, 44, 0};
  int num_errors = 0, samples_checked = 0, i, n;

  always #12.5 clk = ~clk;

  cdp_ctrl DUT (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(rdata), .playback_left_gain(pl_l),
    .playback_right_gain(pl_r), .sample_strobe(sample_strobe), .rec_valid(rec_valid),
    .rec_left_in(in_l), .rec_right_in(in_r), .rec_out_valid(out_v), .rec_left_out(out_l),
    .rec_right_out(out_r), .applied_left_gain(app_l), .applied_right_gain(app_r),
    .playback_filter_shape(shape), .left_sidetone_source(src_l),
    .right_sidetone_source(src_r), .left_sidetone_gain(sv_l), .right_sidetone_gain(sv_r),
    .record_highpass_on(hp_on), .record_highpass_cutoff(cut), .record_left_on(on_l),
    .record_right_on(on_r), .record_left_gain(g_l), .record_right_gain(g_r),
    .record_clock_invert(clk_inv), .record_rate_tick(tick)
  );
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // Saturating inversion keeps the most negative sample from wrapping to itself.
  function automatic logic [15:0] exp_rec(logic [15:0] x, logic inv, logic [7:0] g);
    if (g == 8'h00) return 16'h0000;
    if (!inv) return x;
    return (x == 16'h8000) ? 16'h7FFF : -x;
  endfunction : exp_rec

  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  task automatic wr(logic [7:0] a, logic [15:0] x);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = x;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(logic [7:0] a, logic [15:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
    `CHK("reg_rdata", e, rdata)
  endtask : rd

  task automatic samples(int k);
    repeat (k) begin
      sample_strobe = 1'b1;
      cyc(1);
      sample_strobe = 1'b0;
      cyc(3);
    end
  endtask : samples

  task automatic complete_run();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    num_errors++;
    complete_run();
  end

  initial begin
    cyc(4);
    rst_n = 1'b1;
    foreach (ra[j]) rd(ra[j], rv[j]);
    sh = rv;
    {pend_l, pend_r, act_l, act_r} = {4{8'hC0}};
    wr(8'h3C, 16'h3C00);
    sh[2] = 16'h3C00;
    repeat (60) begin
      i = rnd() % 8;
      d = 16'(rnd());
      wr(ra[i], d);
      sh[i] = d & mk[i];
      if (i == 4) pend_l = d[7:0];
      if (i == 5) pend_r = d[7:0];
      if ((i == 4 || i == 5) && d[8]) {act_l, act_r} = {pend_l, pend_r};
      cyc(1);
      rd(ra[i], d & mk[i]);
      `CHK("left gain", act_l, g_l)
      `CHK("right gain", act_r, g_r)
      `CHK("shape", sh[1][12], shape)
      `CHK("src l", sh[2][13:12] == 2'h3 ? 2'h0 : sh[2][13:12], src_l)
      `CHK("src r", sh[2][11:10] == 2'h3 ? 2'h0 : sh[2][11:10], src_r)
      `CHK("hpf", {sh[3][15], sh[3][9:8]}, {hp_on, cut})
      `CHK("side gain", sh[6][11:3], {sv_l, sv_r, clk_inv})
      `CHK("rec on", {sh[4][15], sh[5][15]}, {on_l, on_r})
    end
    wr(8'h42, 16'h0000);
    wr(8'h43, 16'h0133);
    {act_l, act_r} = {8'h00, 8'h33};
    for (int k = 0; k < 4; k++) begin
      wr(8'h40, 16'(k));
      if (k == 2) wr(8'h42, 16'h0110);
      if (k == 2) act_l = 8'h10;
      repeat (4) begin
        in_l = 16'(rnd());
        in_r = (k == 3) ? 16'h8000 : 16'(rnd());
        rec_valid = 1'b1;
        cyc(1);
        `CHK("rec valid", 1'b1, out_v)
        rec_valid = 1'b0;
        cyc(1);
        `CHK("rec left", exp_rec(in_l, k[1], act_l), out_l)
        `CHK("rec right", exp_rec(in_r, k[0], act_r), out_r)
      end
    end
    pl_l = 8'h03;
    pl_r = 8'h03;
    wr(8'h3B, 16'h0000);
    wr(8'h3A, 16'h0000);
    cyc(1);
    `CHK("instant gain", 8'h03, app_l)
    foreach (st[j]) begin
      wr(8'h3A, 16'h4000);
      samples(st[j] * 4);
      `CHK("muted gain", 8'h00, app_r)
      wr(8'h3B, j ? 16'h6000 : 16'h4000);
      wr(8'h3A, 16'h0000);
      samples(st[j] * 2);
      `CHK("ramp early", 1'b1, app_l < 8'h03)
      samples(st[j]);
      `CHK("ramp done", 8'h03, app_l)
    end
    for (int c = 0; c < 8; c++) begin
      wr(8'h44, 16'(c));
      cyc(4);
      n = 0;
      repeat (264) begin
        cyc(1);
        if (tick === 1'b1) n++;
      end
      `CHK("tick count", 1'b1, n >= dv[c] - 1 && n <= dv[c] + 1)
    end
    complete_run();
  end
endmodule : tb_cdp_ctrl
